// ==== src/gii_pkg.sv ====
// package for the bus instrument port: message codes, pin sync reset value,
// fifo sizing and terminator byte; no timing beyond the system clock
package gii_pkg;
  localparam logic [7:0] GII_CMD_MASK   = 8'h7F;
  localparam logic [7:0] GII_CMD_GTL    = 8'h01;
  localparam logic [7:0] GII_CMD_SDC    = 8'h04;
  localparam logic [7:0] GII_CMD_LLO    = 8'h11;
  localparam logic [7:0] GII_CMD_DCL    = 8'h14;
  localparam logic [7:0] GII_CMD_SPE    = 8'h18;
  localparam logic [7:0] GII_CMD_SPD    = 8'h19;
  localparam logic [7:0] GII_CMD_UNL    = 8'h3F;
  localparam logic [7:0] GII_CMD_UNT    = 8'h5F;
  localparam logic [7:0] GII_LAD_BASE   = 8'h20;
  localparam logic [7:0] GII_TAD_BASE   = 8'h40;
  localparam logic [4:0] GII_ADDR_MASK  = 5'h1F;
  localparam logic [7:0] GII_LF         = 8'h0A;
  localparam int         GII_FIFO_DEPTH = 8;
  localparam int         GII_DATA_W     = 8;
  localparam int         GII_FIFO_W     = 9;   // byte plus end flag
  localparam logic [2:0] GII_SYNC_RST   = 3'h7; // idle lines read high
  typedef enum logic [3:0] {
    GII_LOCS = 4'b0001,
    GII_REMS = 4'b0010,
    GII_RWLS = 4'b0100,
    GII_LWLS = 4'b1000
  } gii_rl_t;
  typedef enum logic [3:0] {
    GII_SRC_IDLE = 4'b0001,
    GII_SRC_WRDY = 4'b0010,
    GII_SRC_DAV  = 4'b0100,
    GII_SRC_REL  = 4'b1000
  } gii_src_t;
endpackage

// ==== src/gii_fifo.sv ====
// small first-in first-out buffer with valid/ready on both sides
// assumes a single clock; flush empties it at once
`timescale 1ns/1ps
module gii_fifo #(
  parameter int W = 9,
  parameter int D = 8
) (
  input  wire logic         clk_sys,
  input  wire logic         resetn,
  input  wire logic         ce,
  input  wire logic         flush,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  logic [W-1:0] mem_r [D];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0]   cnt_r;
  logic          push;
  logic          pop;

  assign in_ready  = (cnt_r != (AW+1)'(D));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rp_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // storage; no reset needed for data words
  always_ff @(posedge clk_sys) begin
    if (ce && push) begin
      mem_r[wp_r] <= in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else if (ce) begin
      if (flush) begin
        wp_r  <= '0;
        rp_r  <= '0;
        cnt_r <= '0;
      end else begin
        if (push) begin
          wp_r <= (wp_r == AW'(D-1)) ? '0 : wp_r + 1'b1;
        end
        if (pop) begin
          rp_r <= (rp_r == AW'(D-1)) ? '0 : rp_r + 1'b1;
        end
        cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
    end
  end
endmodule

// ==== src/gii_port.sv ====
// instrument side of the parallel instrument bus: handshakes, addressing,
// clears, serial poll, remote/local and service request
// assumes bus pins are active low, come from outside, and that the
// wire-and of the open-collector lines is resolved outside this module
`timescale 1ns/1ps
module gii_port
  import gii_pkg::*;
#(
  parameter int         FIFO_DEPTH = GII_FIFO_DEPTH,
  parameter logic [4:0] MY_ADDR    = 5'h06
) (
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  input  wire logic       ce,
  // bus pins, active low; open collector as in/out/oe, atn/ifc/ren inputs only, srq as out/oe
  input  wire logic [7:0] dio_n_i,
  output logic [7:0]      dio_n_o,
  output logic            dio_oe,
  input  wire logic       dav_n_i,
  output logic            dav_n_o,
  output logic            dav_oe,
  input  wire logic       nrfd_n_i,
  output logic            nrfd_n_o,
  output logic            nrfd_oe,
  input  wire logic       ndac_n_i,
  output logic            ndac_n_o,
  output logic            ndac_oe,
  input  wire logic       eoi_n_i,
  output logic            eoi_n_o,
  output logic            eoi_oe,
  input  wire logic       atn_n_i,
  input  wire logic       ifc_n_i,
  input  wire logic       ren_n_i,
  output logic            srq_n_o,
  output logic            srq_oe,
  // instrument side
  output logic [7:0]      rx_data,
  output logic            rx_end,
  output logic            rx_valid,
  input  wire logic       rx_ready,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_last,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  input  wire logic [7:0] status_byte,
  input  wire logic       svc_req,
  output logic            dev_clear,
  output logic            listener,
  output logic            talker,
  output logic            remote,
  output logic            lockout,
  output logic            poll_mode
);
  // three-stage synchronisers: bit0 dav,1 nrfd,2 ndac,3 eoi,4 atn,5 ifc,6 ren
  logic [2:0] sc_r [7];
  logic [6:0] raw;
  logic [6:0] lvl_r;
  logic [7:0] d_s1_r, d_s2_r;
  logic [7:0] d_s3_r, d_lvl_r;
  assign raw = {ren_n_i, ifc_n_i, atn_n_i, eoi_n_i, ndac_n_i, nrfd_n_i,
                dav_n_i};

  // a line changes only when stages two and three agree
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 7; i++) begin
        sc_r[i] <= GII_SYNC_RST;
      end
      lvl_r  <= '1;
      d_s1_r <= '1;
      d_s2_r <= '1;
      d_s3_r <= '1;
      d_lvl_r <= '1;
    end else if (ce) begin
      for (int i = 0; i < 7; i++) begin
        sc_r[i] <= {sc_r[i][1:0], raw[i]};
        if (sc_r[i][1] == sc_r[i][2]) begin
          lvl_r[i] <= sc_r[i][2];
        end
      end
      d_s1_r <= dio_n_i;
      d_s2_r <= d_s1_r;
      d_s3_r <= d_s2_r;
      d_lvl_r <= (d_s2_r & d_s3_r) | (d_lvl_r & (d_s2_r ^ d_s3_r));
    end
  end

  logic       dav, nrfd_bus, ndac_bus, eoi, atn, ifc, ren;
  logic [7:0] bus_byte;
  assign dav      = !lvl_r[0];
  assign nrfd_bus = lvl_r[1];   // high = everyone ready
  assign ndac_bus = lvl_r[2];   // high = everyone accepted
  assign eoi      = !lvl_r[3];
  assign atn      = !lvl_r[4];
  assign ifc      = !lvl_r[5];
  assign ren      = !lvl_r[6];
  assign bus_byte = ~d_lvl_r;   // data settles a cycle before dav

  // acceptor state
  logic       acc_r;     // byte accepted, waiting for dav release
  logic       dav_q_r;
  logic       take;
  logic [7:0] cmd;
  logic       fifo_in_rdy;
  logic       lsn_r, tlk_r, spe_r, rem_r, llo_r;
  logic       flush;

  assign take = dav && !dav_q_r && !acc_r;
  assign cmd  = bus_byte & GII_CMD_MASK;

  // dav edge memory
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      dav_q_r <= 1'b0;
    end else if (ce) begin
      dav_q_r <= dav;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      acc_r <= 1'b0;
    end else if (ce) begin
      if (take && (atn || (lsn_r && fifo_in_rdy))) begin
        acc_r <= 1'b1;
      end else if (!dav) begin
        acc_r <= 1'b0;
      end
    end
  end

  logic is_my_lad, is_my_tad, is_cmd;
  assign is_cmd    = take && atn;
  assign is_my_lad = (cmd == (GII_LAD_BASE | {3'h0, MY_ADDR}));
  assign is_my_tad = (cmd == (GII_TAD_BASE | {3'h0, MY_ADDR}));

  // addressing; interface clear unaddresses
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      lsn_r <= 1'b0;
      tlk_r <= 1'b0;
    end else if (ce) begin
      if (ifc) begin
        lsn_r <= 1'b0;
        tlk_r <= 1'b0;
      end else if (is_cmd) begin
        if (is_my_lad) begin
          lsn_r <= 1'b1;
        end else if (cmd == GII_CMD_UNL) begin
          lsn_r <= 1'b0;
        end
        if (is_my_tad) begin
          tlk_r <= 1'b1;
        end else if (cmd == GII_CMD_UNT ||
                     (cmd[6:5] == 2'b10 && !is_my_tad)) begin
          tlk_r <= 1'b0;   // another talker takes the bus
        end
      end
    end
  end

  // poll enable sticks; disable clears it
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      spe_r <= 1'b0;
    end else if (ce) begin
      if (ifc || (is_cmd && cmd == GII_CMD_SPD)) begin
        spe_r <= 1'b0;
      end else if (is_cmd && cmd == GII_CMD_SPE) begin
        spe_r <= 1'b1;
      end
    end
  end

  assign flush = is_cmd && ((cmd == GII_CMD_DCL) ||
                            (cmd == GII_CMD_SDC && lsn_r));
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      dev_clear <= 1'b0;
    end else if (ce) begin
      dev_clear <= flush;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rem_r <= 1'b0;
      llo_r <= 1'b0;
    end else if (ce) begin
      if (!ren) begin
        rem_r <= 1'b0;
        llo_r <= 1'b0;
      end else begin
        if (is_cmd && cmd == GII_CMD_LLO) begin
          llo_r <= 1'b1;
        end
        if (is_cmd && cmd == GII_CMD_GTL && lsn_r) begin
          rem_r <= 1'b0;
        end else if (is_cmd && is_my_lad) begin
          rem_r <= 1'b1;
        end
      end
    end
  end

  // receive path; end flag rides with the byte
  logic rx_push;
  assign rx_push = take && !atn && lsn_r && fifo_in_rdy;
  logic [8:0] rx_word;
  gii_fifo #(.W(GII_FIFO_W), .D(FIFO_DEPTH)) u_rx_fifo (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .ce        (ce),
    .flush     (flush),
    .in_data   ({eoi, bus_byte}),
    .in_valid  (rx_push),
    .in_ready  (fifo_in_rdy),
    .out_data  (rx_word),
    .out_valid (rx_valid),
    .out_ready (rx_ready)
  );
  assign rx_data = rx_word[7:0];
  assign rx_end  = rx_word[8];

  // transmit path, buffered as well so clears can empty it
  logic [8:0] tx_word;
  logic       tx_av;
  logic       tx_pop;
  gii_fifo #(.W(GII_FIFO_W), .D(FIFO_DEPTH)) u_tx_fifo (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .ce        (ce),
    .flush     (flush),
    .in_data   ({tx_last, tx_data}),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .out_data  (tx_word),
    .out_valid (tx_av),
    .out_ready (tx_pop)
  );

  // source handshake, order ready, valid, accepted, release
  gii_src_t   src_r;
  logic [7:0] out_r;
  logic       out_eoi_r;
  logic       poll_r;
  logic       can_talk;
  assign can_talk = tlk_r && !atn && !ifc;
  // poll answer wins over any pending reply
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      src_r     <= GII_SRC_IDLE;
      out_r     <= '0;
      out_eoi_r <= 1'b0;
      poll_r    <= 1'b0;
    end else if (ce) begin
      unique case (src_r)
        GII_SRC_IDLE: begin
          if (can_talk && (spe_r || tx_av)) begin
            poll_r <= spe_r;
            // status byte with pending request bit
            out_r <= spe_r ? {status_byte[7], svc_req, status_byte[5:0]}
                           : tx_word[7:0];
            out_eoi_r <= !spe_r && tx_word[8] && tx_word[7:0] == GII_LF;
            src_r     <= GII_SRC_WRDY;
          end
        end
        GII_SRC_WRDY: begin
          if (!can_talk) begin
            src_r <= GII_SRC_IDLE;
          end else if (nrfd_bus) begin
            src_r <= GII_SRC_DAV;
          end
        end
        GII_SRC_DAV: begin
          if (ifc) begin
            src_r <= GII_SRC_IDLE;
          end else if (ndac_bus) begin
            src_r <= GII_SRC_REL;
          end
        end
        GII_SRC_REL: begin
          src_r <= GII_SRC_IDLE;
        end
      endcase
    end
  end
  // pop the reply byte only when it was accepted, not a poll answer
  assign tx_pop = ce && src_r == GII_SRC_REL && !poll_r;

  // valid asserted only while data driven and stable
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      dio_n_o <= '1;
      dio_oe  <= 1'b0;
      dav_n_o <= 1'b1;
      dav_oe  <= 1'b0;
      eoi_n_o <= 1'b1;
      eoi_oe  <= 1'b0;
    end else if (ce) begin
      dio_oe  <= (src_r == GII_SRC_WRDY) || (src_r == GII_SRC_DAV);
      dio_n_o <= ~out_r;
      dav_oe  <= (src_r == GII_SRC_DAV);
      dav_n_o <= !(src_r == GII_SRC_DAV);
      // end held with the final line feed
      eoi_oe  <= out_eoi_r && src_r inside {GII_SRC_WRDY, GII_SRC_DAV};
      eoi_n_o <= !(out_eoi_r && src_r inside {GII_SRC_WRDY, GII_SRC_DAV});
    end
  end

  // acceptor lines; under attention every device must take part
  logic acc_on;
  assign acc_on = atn || lsn_r;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      nrfd_oe  <= 1'b0;
      nrfd_n_o <= 1'b1;
      ndac_oe  <= 1'b0;
      ndac_n_o <= 1'b1;
    end else if (ce) begin
      // not-ready held low until a byte can be taken
      nrfd_oe  <= acc_on && (acc_r || !(atn || fifo_in_rdy) || dav);
      nrfd_n_o <= !(acc_on && (acc_r || !(atn || fifo_in_rdy) || dav));
      // not-accepted low until this byte is taken
      ndac_oe  <= acc_on && !acc_r;
      ndac_n_o <= !(acc_on && !acc_r);
    end
  end

  // service request while asked and not being polled
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      srq_oe  <= 1'b0;
      srq_n_o <= 1'b1;
    end else if (ce) begin
      srq_oe  <= svc_req && !spe_r;
      srq_n_o <= !(svc_req && !spe_r);
    end
  end

  assign listener  = lsn_r;
  assign talker    = tlk_r;
  assign remote    = rem_r;
  assign lockout   = llo_r;
  assign poll_mode = spe_r;
endmodule

// ==== sim/gii_port_checker.sv ====
// pin-level assertions for the instrument bus port
// bound to the port from the bench top file; sees its ports only
`timescale 1ns/1ps
module gii_port_checker
  import gii_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       resetn,
  input wire logic [7:0] dio_n_o,
  input wire logic       dio_oe,
  input wire logic       dav_oe,
  input wire logic       nrfd_oe,
  input wire logic       ndac_oe,
  input wire logic       eoi_oe,
  input wire logic       dav_n_i,
  input wire logic       nrfd_n_i,
  input wire logic       ndac_n_i,
  input wire logic       ifc_n_i,
  input wire logic [7:0] status_byte,
  input wire logic       svc_req,
  input wire logic       dev_clear,
  input wire logic       listener,
  input wire logic       talker,
  input wire logic       poll_mode
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  // source handshake order seen from the pins
  dav_data_a: assert property (
    dav_oe |-> dio_oe) else $error("valid without data");
  dav_rise_a: assert property (
    $rose(dav_oe) |-> talker && $past(nrfd_n_i))
    else $error("valid before ready");
  dav_release_a: assert property (
    $fell(dav_oe) |-> $past(ndac_n_i)) else $error("early release");
  // acceptor: taking a byte leaves it not ready
  ndac_order_a: assert property (
    $fell(ndac_oe) && !dav_n_i |-> nrfd_oe)
    else $error("accepted while ready");
  eoi_lf_a: assert property (
    eoi_oe |-> dio_oe && dio_n_o == ~GII_LF) else $error("end not on lf");
  clear_pulse_a: assert property (
    dev_clear |=> !dev_clear) else $error("clear pulse too long");
  ifc_quiet_a: assert property (
    (!ifc_n_i) [*8] |=> !listener && !talker && !poll_mode)
    else $error("addressed during clear");
  poll_byte_a: assert property (
    dav_oe && poll_mode |->
      dio_n_o == ~{status_byte[7], svc_req, status_byte[5:0]})
    else $error("wrong poll byte");
endmodule

// ==== sim/gii_ctl_model.sv ====
// bus controller model: source of commands and data, listener for replies
// assumes wired-and lines resolved by the bench, pulled up when released
`timescale 1ns/1ps
module gii_ctl_model (
  input  wire logic       clk_sys,
  input  wire logic [7:0] dio_n_i,
  input  wire logic       dav_n_i,
  input  wire logic       nrfd_n_i,
  input  wire logic       ndac_n_i,
  input  wire logic       eoi_n_i,
  output logic [7:0]      m_dio_n,
  output logic            m_dav_n,
  output logic            m_nrfd_n,
  output logic            m_ndac_n,
  output logic            m_eoi_n,
  output logic            atn_n_i,
  output logic            got,
  output logic [8:0]      got_w,
  output logic            hung
);
  // idle: lines released, not ready, so a talker cannot lose bytes
  initial begin
    {m_dio_n, m_dav_n, m_eoi_n, atn_n_i} = 11'h7FF;
    {m_nrfd_n, m_ndac_n, got, hung} = 4'h0;
    got_w = 9'h000;
  end

  // bounded wait on a line: 0 valid, 1 ready, 2 accepted
  task automatic wt(input int i, input logic v);
    int k;
    logic [2:0] ln;
    for (k = 0; k < 500; k++) begin
      ln = {ndac_n_i, nrfd_n_i, dav_n_i};
      if (ln[i] === v) break;
      @(negedge clk_sys);
    end
    if (k == 500) hung = 1'b1;
  endtask

  // source: ready, valid, all accepted, release
  task automatic send(input logic [7:0] b, input logic atn, input logic e,
                      input logic acc = 1'b1);
    @(negedge clk_sys);
    atn_n_i = ~atn;
    repeat (6) @(negedge clk_sys);
    {m_nrfd_n, m_ndac_n} = 2'b11;
    if (acc) wt(2, 1'b0);
    wt(1, 1'b1);
    {m_dio_n, m_eoi_n} = {~b, ~e};
    @(negedge clk_sys);
    m_dav_n = 1'b0;
    wt(2, 1'b1);
    @(negedge clk_sys);
    {m_dav_n, m_eoi_n, m_dio_n} = 10'h3FF;
    repeat (6) @(negedge clk_sys);
    {atn_n_i, m_nrfd_n, m_ndac_n} = 3'b100;
  endtask

  // listener: ready, take byte, accepted, wait for release
  task automatic take(input int n);
    repeat (n) begin
      @(negedge clk_sys);
      {m_nrfd_n, m_ndac_n} = 2'b10;
      wt(0, 1'b0);
      @(negedge clk_sys);
      got_w = {~eoi_n_i, ~dio_n_i};
      {m_nrfd_n, m_ndac_n, got} = 3'b011;
      @(negedge clk_sys);
      got = 1'b0;
      wt(0, 1'b1);
      m_ndac_n = 1'b0;
    end
    m_nrfd_n = 1'b0;
  endtask
endmodule

// ==== sim/tb_top.sv ====
// bench top: instrument port facing a controller model on a wired-and bus
// assumes 125 MHz clock, reset held 3 cycles, noted results in queues
`timescale 1ns/1ps
module tb_top;
  import gii_pkg::*;
  localparam logic [7:0] ADR = 8'h06;
  logic       clk_sys = 1'b0;
  logic       resetn = 1'b0;
  logic       ce = 1'b1;
  logic       ifc_n_i = 1'b1;
  logic       ren_n_i = 1'b1;
  logic       rx_ready = 1'b1;
  logic       svc_req = 1'b0;
  logic [7:0] status_byte = 8'h00;
  logic [7:0] tx_data = 8'h00;
  logic       tx_last = 1'b0;
  logic       tx_valid = 1'b0;
  logic [7:0] dio_n_o, rx_data, m_dio_n;
  logic dio_oe, dav_n_o, dav_oe, nrfd_n_o, nrfd_oe, ndac_n_o, ndac_oe;
  logic eoi_n_o, eoi_oe, srq_n_o, srq_oe, rx_end, rx_valid, tx_ready;
  logic dev_clear, listener, talker, remote, lockout, poll_mode;
  logic m_dav_n, m_nrfd_n, m_ndac_n, m_eoi_n, atn_n_i, got, hung;
  logic [8:0] got_w;
  logic [8:0] rxq[$], txq[$];
  int fail_count = 0;
  int compares = 0;
  int clr_seen = 0;
  int seed = 32'hB747;
  // wired-and: a pulled line reads low for everyone
  wire [7:0] dio_n_i = m_dio_n & ~({8{dio_oe}} & ~dio_n_o);
  wire dav_n_i = m_dav_n & ~(dav_oe & ~dav_n_o);
  wire nrfd_n_i = m_nrfd_n & ~(nrfd_oe & ~nrfd_n_o);
  wire ndac_n_i = m_ndac_n & ~(ndac_oe & ~ndac_n_o);
  wire eoi_n_i = m_eoi_n & ~(eoi_oe & ~eoi_n_o);

  always #4 clk_sys = ~clk_sys;
  gii_port dut (.*);
  gii_ctl_model ctl (.*);

  task automatic chk_w(input string nm, input logic [8:0] e,
                       input logic [8:0] s);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic chk_b(input string nm, input logic e, input logic s);
    chk_w(nm, {8'h00, e}, {8'h00, s});
  endtask
  task automatic conclude();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // a waiting loop that ran out ends the run as a failure
  task automatic drain();
    int k;
    for (k = 0; k < 400 && (rxq.size() || txq.size()); k++)
      @(negedge clk_sys);
    if (k == 400) begin
      fail_count++;
      conclude();
    end
  endtask
  always @(posedge hung) begin
    fail_count++;
    conclude();
  end
  // watcher: each result takes the oldest note; no note means unexpected
  always @(posedge clk_sys) begin
    if (rx_valid === 1'b1 && rx_ready === 1'b1)
      chk_w("rx", rxq.size() ? rxq.pop_front() : 9'hXXX, {rx_end, rx_data});
    if (got === 1'b1)
      chk_w("bus", txq.size() ? txq.pop_front() : 9'hXXX, got_w);
    if (dev_clear === 1'b1) clr_seen++;
  end
  task automatic push(input logic [7:0] b, input logic l);
    @(negedge clk_sys);
    chk_b("tx_ready", 1'b1, tx_ready);
    {tx_data, tx_last, tx_valid} = {b, l, 1'b1};
    txq.push_back({l && b == GII_LF, b});
  endtask

  initial begin
    logic [7:0] b;
    repeat (3) @(negedge clk_sys);
    resetn = 1'b1;
    ctl.send(8'h55, 1'b0, 1'b0, 1'b0);
    ren_n_i = 1'b0;
    ctl.send(GII_LAD_BASE | ADR, 1'b1, 1'b0);
    chk_b("listener", 1'b1, listener);
    chk_b("remote", 1'b1, remote);
    // fill with the reader stalled, then drain
    rx_ready = 1'b0;
    for (int i = 0; i < GII_FIFO_DEPTH; i++) begin
      b = 8'($random(seed));
      rxq.push_back({i == GII_FIFO_DEPTH - 1, b});
      ctl.send(b, 1'b0, i == GII_FIFO_DEPTH - 1);
    end
    repeat (8) @(negedge clk_sys);
    chk_b("nrfd_oe", 1'b1, nrfd_oe);
    rx_ready = 1'b1;
    drain();
    rx_ready = 1'b0;
    ctl.send(8'h31, 1'b0, 1'b0);
    ctl.send(GII_CMD_SDC, 1'b1, 1'b0);
    chk_b("rx_valid", 1'b0, rx_valid);
    rx_ready = 1'b1;
    ctl.send(GII_CMD_UNL, 1'b1, 1'b0);
    ctl.send(GII_CMD_SDC, 1'b1, 1'b0);
    ctl.send(8'h32, 1'b0, 1'b0, 1'b0);
    ctl.send(GII_CMD_DCL, 1'b1, 1'b0);
    chk_w("clears", 9'(clr_seen), 9'h002);
    // lockout, go to local, remote enable dropped
    ctl.send(GII_LAD_BASE | ADR, 1'b1, 1'b0);
    ctl.send(GII_CMD_LLO, 1'b1, 1'b0);
    chk_b("lockout", 1'b1, lockout);
    ctl.send(GII_CMD_GTL, 1'b1, 1'b0);
    chk_b("remote", 1'b0, remote);
    // clock enable low freezes the port, remote enable drop unseen
    ce = 1'b0;
    ren_n_i = 1'b1;
    repeat (8) @(negedge clk_sys);
    chk_b("lockout", 1'b1, lockout);
    ce = 1'b1;
    repeat (8) @(negedge clk_sys);
    chk_b("lockout", 1'b0, lockout);
    // end only on a final line feed
    ctl.send(GII_CMD_UNL, 1'b1, 1'b0);
    ctl.send(GII_TAD_BASE | ADR, 1'b1, 1'b0);
    chk_b("talker", 1'b1, talker);
    push(8'($random(seed)) | 8'h80, 1'b0);
    push(GII_LF, 1'b0);
    push(GII_LF, 1'b1);
    @(negedge clk_sys);
    tx_valid = 1'b0;
    ctl.take(3);
    drain();
    ctl.send(GII_CMD_UNT, 1'b1, 1'b0);
    chk_b("talker", 1'b0, talker);
    // serial poll answers with the status byte
    status_byte = 8'($random(seed));
    svc_req = 1'b1;
    repeat (8) @(negedge clk_sys);
    chk_b("srq_oe", 1'b1, srq_oe);
    chk_b("srq_n_o", 1'b0, srq_n_o);
    ctl.send(GII_CMD_SPE, 1'b1, 1'b0);
    ctl.send(GII_TAD_BASE | ADR, 1'b1, 1'b0);
    chk_b("poll_mode", 1'b1, poll_mode);
    chk_b("srq_oe", 1'b0, srq_oe);
    txq.push_back({1'b0, status_byte[7], 1'b1, status_byte[5:0]});
    ctl.take(1);
    ctl.send(GII_CMD_SPD, 1'b1, 1'b0);
    chk_b("poll_mode", 1'b0, poll_mode);
    ctl.send(GII_LAD_BASE | ADR, 1'b1, 1'b0);
    ifc_n_i = 1'b0;
    repeat (10) @(negedge clk_sys);
    ifc_n_i = 1'b1;
    chk_b("listener", 1'b0, listener);
    chk_b("talker", 1'b0, talker);
    drain();
    conclude();
  end
endmodule

bind gii_port gii_port_checker chk (.*);
